// *** rtl/bmc_pkg.sv ***
package bmc_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS  = 100;   // system clock period
  localparam int FAST_PERIOD_US = 1000;  // 1 kHz sampling period
  localparam int SLOW_PERIOD_US = 8000;  // 125 Hz sampling period
  localparam int FAST_CYCLES    = FAST_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int SLOW_CYCLES    = SLOW_PERIOD_US * 1000 / CLK_PERIOD_NS;

  // ==========================================================
  // register indexes, byte address is four times the index
  localparam int            ADDR_W        = 6;
  localparam logic [3:0]    IDX_MODE_CTRL = 4'h0;  // detector_mode_control
  localparam logic [3:0]    IDX_THRESHOLD = 4'h1;  // detector_threshold_level
  localparam logic [3:0]    IDX_OFFSET    = 4'h8;  // warning_offset_control
  localparam logic [3:0]    IDX_INT_CTRL  = 4'h9;  // warning_interrupt_control
  localparam logic [3:0]    IDX_INT_FLAGS = 4'ha;  // warning_interrupt_flags
  localparam logic [3:0]    IDX_STATUS    = 4'hb;  // warning_status
  localparam logic [3:0]    IDX_UNLOCK    = 4'hc;  // protected_write_unlock key

  // ==========================================================
  // field positions
  localparam int SLEEP_LSB = 0;  // sleep-mode field, bits 1:0
  localparam int RUN_LSB   = 2;  // run-mode field, bits 3:2
  localparam int RATE_BIT  = 4;  // sample_rate_select
  localparam int LEVEL_LSB = 0;  // threshold_level_field, bits 2:0
  localparam int OFS_LSB   = 0;  // warning_offset_field, bits 1:0
  localparam int IE_BIT    = 0;  // warning_interrupt_enable
  localparam int TRIG_LSB  = 1;  // warning_trigger_select, bits 2:1
  localparam int FLAG_BIT  = 0;  // warning_flag
  localparam int STAT_BIT  = 0;  // warning_status_bit

  // ==========================================================
  // reset values and unlock window
  localparam logic [1:0] OFFSET_RST    = 2'h0;
  localparam logic [1:0] TRIG_RST      = 2'h0;
  localparam logic [2:0] UNLOCK_WINDOW = 3'h4;  // accesses after key

  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    MODE_OFF       = 2'h0,  // mode_off
    MODE_CONT      = 2'h1,
    MODE_SAMPLED   = 2'h2,
    MODE_HOLD_WAKE = 2'h3   // continuous_hold_at_wake
  } bmc_mode_t;

  typedef enum logic [1:0] {
    TRIG_BELOW  = 2'h0,
    TRIG_ABOVE  = 2'h1,
    TRIG_EITHER = 2'h2      // trigger_either
  } bmc_trig_t;

  localparam logic [1:0] OFS_5PCT  = 2'h0;
  localparam logic [1:0] OFS_15PCT = 2'h1;
  localparam logic [1:0] OFS_25PCT = 2'h2;
  localparam logic [2:0] THR_1V8   = 3'h0;  // threshold_code_zero
  localparam logic [2:0] THR_2V6   = 3'h2;
  localparam logic [2:0] THR_4V2   = 3'h7;

  typedef enum logic [2:0] {
    PS_ACTIVE = 3'h1,
    PS_SLEEP  = 3'h2,
    PS_WAKE   = 3'h4
  } bmc_pwr_t;

  // fuse contents caught at reset
  typedef struct packed {
    logic       rate;
    logic [1:0] run_mode;
    logic [1:0] sleep_mode;
    logic [2:0] level;
  } bmc_fuse_t;

  // whole state of the control block
  typedef struct packed {
    logic       rate;
    logic [1:0] run_mode;
    logic [1:0] sleep_mode;
    logic [2:0] level;
    logic [1:0] offset;
    logic [1:0] trig;
    logic       ie;
    logic       flag;
    logic       status;
    logic [2:0] unlock_cnt;
    logic       wait_n;
    logic [7:0] rdata;
    logic       irq;
    bmc_pwr_t   pwr;
    logic [1:0] eff_mode;
    logic       hold;
  } bmc_state_t;

endpackage : bmc_pkg

// *** rtl/bmc_sample_tick.sv ***
module bmc_sample_tick
  import bmc_pkg::*;
#(
  parameter int FAST = FAST_CYCLES,
  parameter int SLOW = SLOW_CYCLES
) (
  input  wire logic clk,     // system clock
  input  wire logic rst,     // synchronous reset
  input  wire logic enable,  // sampled mode active
  input  wire logic slow,    // 1 selects the slow rate
  output logic      tick     // one-cycle sample strobe
);

  // ==========================================================
  // period counter
  logic [16:0] cnt_r;
  logic [16:0] limit;

  // last count of the selected period
  assign limit = slow ? 17'(SLOW - 1) : 17'(FAST - 1);

  // counter restarts whenever sampling stops
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      cnt_r <= 17'h0;
      tick  <= 1'b0;
    end else if (cnt_r >= limit) begin
      cnt_r <= 17'h0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 17'h1;
      tick  <= 1'b0;
    end
  end

endmodule : bmc_sample_tick

// *** rtl/bmc_control.sv ***
// ==========================================================
// Function
// - rate bit picks 1 kHz or 125 Hz
// - rate bit fuse-loaded, writable without unlock
// - run mode codes off, cont, sampled, hold
// - run mode bits 3:2 read-only, fuse-loaded
// - sleep mode bits 1:0 writable, fuse-loaded
// - threshold code read-only, fuse-loaded
// - offset codes give 5, 15, 25 percent
// - trigger codes below, above, either direction
// - enable bit 0 enables warning interrupt
// - flag sets on matching threshold event
// - flag sets only while detector enabled, clear works in every mode
// - status one when supply below threshold
// - status meaningful only while detector enabled
// - sleep uses sleep mode, wake uses run
// - monitor follows detector mode, continuous or sampled
// - interrupt while flag and enable set
// - sleep mode write needs recent unlock key
//
// The Avalon-MM register port was left to the implementer.
module bmc_control
  import bmc_pkg::*;
#(
  parameter int         FAST       = FAST_CYCLES,  // cycles per 1 kHz sample
  parameter int         SLOW       = SLOW_CYCLES,  // cycles per 125 Hz sample
  parameter logic [7:0] UNLOCK_KEY = 8'h5a         // arbitrary key value
) (
  input  wire logic              SYS_CLK,          // system clock
  input  wire logic              RESET,            // synchronous reset
  input  wire logic [ADDR_W-1:0] ADDRESS,          // byte address
  input  wire logic              READ,             // read request
  input  wire logic              WRITE,            // write request
  input  wire logic [31:0]       WRITEDATA,        // write data
  input  wire logic [3:0]        BYTEENABLE,       // byte lanes
  output logic      [31:0]       READDATA,         // read data
  output logic                   WAITREQUEST,      // slave stall
  input  wire bmc_fuse_t         FUSE_CFG,         // fuse contents
  input  wire logic              STANDBY_REQ,      // standby or power-down
  input  wire logic              DETECTOR_READY,   // analog detector running
  input  wire logic              BELOW_WARN,       // supply below warning level
  output logic                   IRQ,              // warning interrupt
  output logic      [1:0]        DET_MODE,         // detector mode now
  output logic                   SAMPLE_RATE,      // sampled-mode rate
  output logic      [2:0]        THRESHOLD_LEVEL,  // threshold code
  output logic      [1:0]        WARNING_OFFSET,   // warning offset code
  output logic                   EXEC_HOLD         // hold execution at wake
);

  // ==========================================================
  // state and sampling strobe
  bmc_state_t st_r;
  bmc_state_t st_nxt;
  logic       tick;

  // sampled-mode strobe at the chosen rate
  bmc_sample_tick #(
    .FAST (FAST),
    .SLOW (SLOW)
  ) u_tick (
    .clk    (SYS_CLK),
    .rst    (RESET),
    .enable (st_r.eff_mode == MODE_SAMPLED),
    .slow   (st_r.rate),
    .tick   (tick)
  );

  // ==========================================================
  // bus decode
  logic       req;
  logic       done;
  logic       wr_en;
  logic       mapped;
  logic [3:0] idx;
  logic [7:0] wbyte;

  // a request completes on the edge where waitrequest is low
  assign req    = READ | WRITE;
  assign done   = req & ~st_r.wait_n;
  assign idx    = ADDRESS[ADDR_W-1:2];
  assign mapped = (ADDRESS[1:0] == 2'h0);
  assign wr_en  = WRITE & done & BYTEENABLE[0] & mapped;
  assign wbyte  = WRITEDATA[7:0];

  // ==========================================================
  // monitor events
  logic upd;
  logic went_below;
  logic went_above;
  logic set_evt;
  logic clr_flag;
  logic det_on;

  // detector enabled in every mode but off
  assign det_on = (st_r.eff_mode != MODE_OFF);

  // comparator level is taken every cycle, or per strobe when sampled
  assign upd = (st_r.eff_mode == MODE_CONT) |
               (st_r.eff_mode == MODE_HOLD_WAKE) |
               ((st_r.eff_mode == MODE_SAMPLED) & tick);

  // crossings seen against the last stored level
  assign went_below = upd & BELOW_WARN & ~st_r.status;
  assign went_above = upd & ~BELOW_WARN & st_r.status;

  // trigger selection, reserved code gives no event
  always_comb begin
    unique case (st_r.trig)
      TRIG_BELOW:  set_evt = went_below;
      TRIG_ABOVE:  set_evt = went_above;
      TRIG_EITHER: set_evt = went_below | went_above;
      default:     set_evt = 1'b0;
    endcase
  end

  // software clear of the flag
  assign clr_flag = wr_en & (idx == IDX_INT_FLAGS) & wbyte[FLAG_BIT];

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;

    // ---- unlock window counts completed accesses
    if (wr_en && idx == IDX_UNLOCK && wbyte == UNLOCK_KEY) begin
      st_nxt.unlock_cnt = UNLOCK_WINDOW;
    end else if (done && st_r.unlock_cnt != 3'h0) begin
      st_nxt.unlock_cnt = st_r.unlock_cnt - 3'h1;
    end

    // ---- register writes
    if (wr_en) begin
      unique case (idx)
        IDX_MODE_CTRL: begin
          st_nxt.rate = wbyte[RATE_BIT];
          if (st_r.unlock_cnt != 3'h0) begin
            st_nxt.sleep_mode = wbyte[SLEEP_LSB +: 2];
          end
        end
        IDX_OFFSET: begin
          st_nxt.offset = wbyte[OFS_LSB +: 2];
        end
        IDX_INT_CTRL: begin
          st_nxt.ie   = wbyte[IE_BIT];
          st_nxt.trig = wbyte[TRIG_LSB +: 2];
        end
        default: begin
        end
      endcase
    end

    // ---- warning status follows comparator only while running
    if (upd) begin
      st_nxt.status = BELOW_WARN;
    end

    // ---- flag: clear by one, set wins, set blocked while detector off
    if (clr_flag) begin
      st_nxt.flag = 1'b0;
    end
    if (det_on && set_evt) begin
      st_nxt.flag = 1'b1;
    end

    // ---- power state
    unique case (st_r.pwr)
      PS_ACTIVE: begin
        if (STANDBY_REQ) begin
          st_nxt.pwr = PS_SLEEP;
        end
      end
      PS_SLEEP: begin
        if (!STANDBY_REQ) begin
          st_nxt.pwr = (st_r.run_mode == MODE_HOLD_WAKE) ? PS_WAKE : PS_ACTIVE;
        end
      end
      PS_WAKE: begin
        if (DETECTOR_READY) begin
          st_nxt.pwr = PS_ACTIVE;
        end
      end
      default: begin
        st_nxt.pwr = PS_ACTIVE;
      end
    endcase

    // ---- fuse load on reset
    if (RESET) begin
      st_nxt            = '0;
      st_nxt.rate       = FUSE_CFG.rate;
      st_nxt.run_mode   = FUSE_CFG.run_mode;
      st_nxt.sleep_mode = FUSE_CFG.sleep_mode;
      st_nxt.level      = FUSE_CFG.level;
      st_nxt.offset     = OFFSET_RST;
      st_nxt.trig       = TRIG_RST;
      st_nxt.wait_n     = 1'b1;
      st_nxt.pwr        = PS_ACTIVE;
    end

    // ---- mode in force: sleep field asleep, run field awake
    if (st_nxt.pwr == PS_SLEEP) begin
      st_nxt.eff_mode = (st_nxt.sleep_mode == MODE_HOLD_WAKE) ? MODE_OFF
                                                             : st_nxt.sleep_mode;
    end else begin
      st_nxt.eff_mode = st_nxt.run_mode;
    end
    st_nxt.hold = (st_nxt.pwr == PS_WAKE);

    // ---- interrupt aligned with the registered flag
    st_nxt.irq = st_nxt.flag & st_nxt.ie;

    // ---- bus answer one cycle after a request is seen
    if (!RESET) begin
      st_nxt.wait_n = ~(req & st_r.wait_n);
      if (req && st_r.wait_n) begin
        st_nxt.rdata = 8'h00;
        if (READ && mapped) begin
          unique case (idx)
            IDX_MODE_CTRL: begin
              st_nxt.rdata[RATE_BIT]      = st_r.rate;
              st_nxt.rdata[RUN_LSB +: 2]  = st_r.run_mode;
              st_nxt.rdata[SLEEP_LSB +: 2] = st_r.sleep_mode;
            end
            IDX_THRESHOLD: st_nxt.rdata[LEVEL_LSB +: 3] = st_r.level;
            IDX_OFFSET:    st_nxt.rdata[OFS_LSB +: 2]   = st_r.offset;
            IDX_INT_CTRL: begin
              st_nxt.rdata[IE_BIT]        = st_r.ie;
              st_nxt.rdata[TRIG_LSB +: 2] = st_r.trig;
            end
            IDX_INT_FLAGS: st_nxt.rdata[FLAG_BIT] = st_r.flag;
            IDX_STATUS:    st_nxt.rdata[STAT_BIT] = st_r.status;
            default:       st_nxt.rdata = 8'h00;
          endcase
        end
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge SYS_CLK) begin
    st_r <= st_nxt;
  end

  // ==========================================================
  // outputs straight from state
  assign READDATA        = {24'h0, st_r.rdata};
  assign WAITREQUEST     = st_r.wait_n;
  assign IRQ             = st_r.irq;
  assign DET_MODE        = st_r.eff_mode;
  assign SAMPLE_RATE     = st_r.rate;
  assign THRESHOLD_LEVEL = st_r.level;
  assign WARNING_OFFSET  = st_r.offset;
  assign EXEC_HOLD       = st_r.hold;

  // ==========================================================
  // assertions
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  // bus answers after one wait cycle, then stalls again
  sequence s_answer;
    ##1 !WAITREQUEST ##1 WAITREQUEST;
  endsequence
  property p_bus_answer;
    (req && WAITREQUEST) |-> s_answer;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not one cycle after request");

  property p_rate_write;
    (wr_en && idx == IDX_MODE_CTRL) |=> (SAMPLE_RATE == $past(WRITEDATA[RATE_BIT]));
  endproperty
  a_rate_write: assert property (p_rate_write)
    else $error("rate bit did not take written value");

  property p_run_fixed;
    !$past(RESET) |-> $stable(st_r.run_mode);
  endproperty
  a_run_fixed: assert property (p_run_fixed)
    else $error("run mode changed outside reset");

  property p_locked_sleep;
    (wr_en && idx == IDX_MODE_CTRL && st_r.unlock_cnt == 3'h0) |=> $stable(st_r.sleep_mode);
  endproperty
  a_locked_sleep: assert property (p_locked_sleep)
    else $error("sleep mode changed without unlock");

  property p_sleep_mode;
    (st_r.pwr == PS_SLEEP && st_r.sleep_mode != MODE_HOLD_WAKE)
      |-> (DET_MODE == st_r.sleep_mode);
  endproperty
  a_sleep_mode: assert property (p_sleep_mode)
    else $error("detector not in sleep mode while asleep");

  property p_flag_frozen;
    (DET_MODE == MODE_OFF && !clr_flag) |=> $stable(st_r.flag);
  endproperty
  a_flag_frozen: assert property (p_flag_frozen)
    else $error("flag moved while detector off");

  property p_irq_level;
    IRQ == (st_r.flag && st_r.ie);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt does not match flag and enable");

  property p_set_wins;
    (det_on && set_evt && clr_flag) |=> st_r.flag;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a simultaneous set");

  sequence s_fall_event;
    det_on && st_r.trig == TRIG_BELOW && went_below;
  endsequence
  property p_flag_set;
    s_fall_event |=> (st_r.flag && st_r.status);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set on matching event");

  property p_sampled_hold;
    (DET_MODE == MODE_SAMPLED && !tick) |=> $stable(st_r.status);
  endproperty
  a_sampled_hold: assert property (p_sampled_hold)
    else $error("status moved between samples");

  // status tracks the comparator every cycle in continuous mode
  property p_status_cont;
    (DET_MODE == MODE_CONT) |=> (st_r.status == $past(BELOW_WARN));
  endproperty
  a_status_cont: assert property (p_status_cont)
    else $error("status did not follow comparator");

  // threshold code never moves outside reset
  property p_level_fixed;
    !$past(RESET) |-> $stable(THRESHOLD_LEVEL);
  endproperty
  a_level_fixed: assert property (p_level_fixed)
    else $error("threshold code changed outside reset");

  // interrupt stays up until the flag is cleared or disabled
  property p_irq_held;
    (IRQ && !clr_flag && !(wr_en && idx == IDX_INT_CTRL)) |=> IRQ;
  endproperty
  a_irq_held: assert property (p_irq_held)
    else $error("interrupt dropped while flag set");

  // wake into mode 3 holds execution until the detector runs
  sequence s_wake_entry;
    st_r.pwr == PS_SLEEP && !STANDBY_REQ && st_r.run_mode == MODE_HOLD_WAKE;
  endsequence
  property p_wake_hold;
    s_wake_entry |=> (EXEC_HOLD && DET_MODE == MODE_HOLD_WAKE);
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("no execution hold at wake");

  property p_wake_release;
    (EXEC_HOLD && DETECTOR_READY) |=> !EXEC_HOLD;
  endproperty
  a_wake_release: assert property (p_wake_release)
    else $error("execution hold kept after detector ready");

endmodule : bmc_control

// *** tb/brownout_monitor_control_test.sv ***
// ==========================================================
// bench for the brown-out control block
module brownout_monitor_control_test
  import bmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int FAST_T = 8;   // short 1 kHz period
  localparam int SLOW_T = 20;  // short 125 Hz period

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
    logic [1:0] op;    // 1 write, 2 write with lane 0 off
    logic [7:0] expv;
  } bmc_row_t;

  logic        sys_clk        = 1'b0;
  logic        reset          = 1'b1;
  logic [5:0]  address        = 6'h00;
  logic        read_req       = 1'b0;
  logic        write_req      = 1'b0;
  logic [31:0] writedata      = 32'h0;
  logic [3:0]  byteenable     = 4'hf;
  bmc_fuse_t   fuse_cfg       = 8'hb7;
  logic        standby_req    = 1'b0;
  logic        detector_ready = 1'b0;
  logic        below_warn     = 1'b0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        irq;
  logic [1:0]  det_mode;
  logic        sample_rate;
  logic [2:0]  threshold_level;
  logic [1:0]  warning_offset;
  logic        exec_hold;
  int          cyc            = 0;
  int          error_cnt      = 0;
  int          check_count    = 0;

  // ordinary register cases, fuse 8'hb7 in force
  bmc_row_t rows [13] = '{
    {6'h20, 8'h01, 2'h1, 8'h01}, {6'h20, 8'h00, 2'h1, 8'h00}, {6'h20, 8'h02, 2'h1, 8'h02},
    {6'h20, 8'h00, 2'h2, 8'h02}, {6'h24, 8'h05, 2'h1, 8'h05}, {6'h24, 8'h03, 2'h1, 8'h03},
    {6'h24, 8'h00, 2'h1, 8'h00}, {6'h04, 8'h00, 2'h1, 8'h07}, {6'h2c, 8'hff, 2'h1, 8'h00},
    {6'h08, 8'hff, 2'h1, 8'h00}, {6'h21, 8'hff, 2'h1, 8'h00}, {6'h00, 8'h00, 2'h1, 8'h06},
    {6'h00, 8'h10, 2'h1, 8'h16}};
  logic [5:0] radr [6] = '{6'h00, 6'h04, 6'h20, 6'h24, 6'h28, 6'h2c};
  logic [7:0] rexp [6] = '{8'h0e, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  bmc_control #(
    .FAST       (FAST_T),
    .SLOW       (SLOW_T),
    .UNLOCK_KEY (8'h5a)
  ) dut (
    .SYS_CLK         (sys_clk),
    .RESET           (reset),
    .ADDRESS         (address),
    .READ            (read_req),
    .WRITE           (write_req),
    .WRITEDATA       (writedata),
    .BYTEENABLE      (byteenable),
    .READDATA        (readdata),
    .WAITREQUEST     (waitrequest),
    .FUSE_CFG        (fuse_cfg),
    .STANDBY_REQ     (standby_req),
    .DETECTOR_READY  (detector_ready),
    .BELOW_WARN      (below_warn),
    .IRQ             (irq),
    .DET_MODE        (det_mode),
    .SAMPLE_RATE     (sample_rate),
    .THRESHOLD_LEVEL (threshold_level),
    .WARNING_OFFSET  (warning_offset),
    .EXEC_HOLD       (exec_hold)
  );

  // ==========================================================
  // clock and cycle count
  always #50 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
  end

  // ==========================================================
  // helpers
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] expv);
    check_count++;
    if (got !== expv) begin
      error_cnt++;
      $display("[ERR] %0t register read %h expected %h", $time, got, expv);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] expv);
    check_count++;
    if (got !== expv) begin
      error_cnt++;
      $display("[ERR] %0t output %h expected %h", $time, got, expv);
    end
  endtask : chk_pin

  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : ticks

  // one bus access, held until waitrequest is seen low
  task automatic bus(input logic [1:0] op, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    address    <= a;
    writedata  <= {24'h000000, d};
    byteenable <= (op == 2'h2) ? 4'he : 4'hf;
    write_req  <= (op != 2'h0);
    read_req   <= (op == 2'h0);
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata[7:0];
    write_req <= 1'b0;
    read_req  <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      $display("[ERR] %0t bus access never answered", $time);
    end
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(2'h1, a, d, q);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] expv);
    logic [7:0] q;
    bus(2'h0, a, 8'h00, q);
    chk_reg(q, expv);
  endtask : rd

  task automatic do_reset(input bmc_fuse_t f);
    @(posedge sys_clk);
    reset    <= 1'b1;
    fuse_cfg <= f;
    ticks(2);
    reset <= 1'b0;
    ticks(1);
  endtask : do_reset

  task automatic wait_irq(output int t);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (irq !== 1'b1 && n < 100);
    t = cyc;
    if (n >= 100) begin
      error_cnt++;
      $display("[ERR] %0t interrupt never rose", $time);
    end
  endtask : wait_irq

  // spacing of two sampled crossings, in cycles
  task automatic gap(input int expv);
    int t0;
    int t1;
    wr(6'h28, 8'h01);
    below_warn <= ~below_warn;
    wait_irq(t0);
    below_warn <= ~below_warn;
    wr(6'h28, 8'h01);
    wait_irq(t1);
    chk_pin(8'(t1 - t0), 8'(expv));
  endtask : gap

  // ==========================================================
  // watchdog
  initial begin
    #(20000 * 100);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] q;
    do_reset(8'hb7);
    foreach (rows[i]) begin
      bus(rows[i].op, rows[i].addr, rows[i].data, q);
      rd(rows[i].addr, rows[i].expv);
    end
    @(negedge sys_clk);
    chk_pin({6'h00, warning_offset}, 8'h02);
    chk_pin({5'h00, threshold_level}, 8'h07);
    chk_pin({7'h00, sample_rate}, 8'h01);
    chk_pin({6'h00, det_mode}, 8'h01);
    @(posedge sys_clk);
    // every trigger code, falling then rising supply
    for (int t = 0; t < 4; t++) begin
      below_warn <= 1'b0;
      ticks(3);
      wr(6'h24, {5'h00, 2'(t), 1'b1});
      wr(6'h28, 8'h01);
      below_warn <= 1'b1;
      ticks(3);
      rd(6'h2c, 8'h01);
      rd(6'h28, {7'h00, t == 0 || t == 2});
      @(negedge sys_clk);
      chk_pin({7'h00, irq}, {7'h00, t == 0 || t == 2});
      wr(6'h28, 8'h00);
      rd(6'h28, {7'h00, t == 0 || t == 2});
      wr(6'h28, 8'h01);
      below_warn <= 1'b0;
      ticks(3);
      rd(6'h28, {7'h00, t == 1 || t == 2});
    end
    // unlock window: fourth access allowed, fifth refused
    wr(6'h30, 8'h5a);
    repeat (3) rd(6'h04, 8'h07);
    wr(6'h00, 8'h14);
    rd(6'h00, 8'h14);
    wr(6'h30, 8'h5a);
    repeat (4) rd(6'h04, 8'h07);
    wr(6'h00, 8'h16);
    rd(6'h00, 8'h14);
    // clear write and crossing land on one edge: set must win
    wr(6'h24, 8'h05);
    fork
      wr(6'h28, 8'h01);
      begin
        ticks(2);
        below_warn <= ~below_warn;
      end
    join
    rd(6'h28, 8'h01);
    // standby with sleep mode off: monitor frozen
    standby_req <= 1'b1;
    ticks(2);
    @(negedge sys_clk);
    chk_pin({6'h00, det_mode}, 8'h00);
    wr(6'h24, 8'h05);
    wr(6'h28, 8'h01);
    below_warn <= 1'b1;
    ticks(3);
    below_warn <= 1'b0;
    ticks(3);
    rd(6'h28, 8'h00);
    standby_req <= 1'b0;
    ticks(2);
    @(negedge sys_clk);
    chk_pin({6'h00, det_mode}, 8'h01);
    // second fuse set, reset values
    do_reset(8'h70);
    @(negedge sys_clk);
    chk_pin({6'h00, det_mode}, 8'h03);
    chk_pin({7'h00, sample_rate}, 8'h00);
    chk_pin({5'h00, threshold_level}, 8'h00);
    chk_pin({6'h00, irq, exec_hold}, 8'h00);
    for (int i = 0; i < 6; i++) rd(radr[i], rexp[i]);
    // sampled sleep mode at both rates
    wr(6'h24, 8'h05);
    standby_req <= 1'b1;
    ticks(2);
    @(negedge sys_clk);
    chk_pin({6'h00, det_mode}, 8'h02);
    gap(FAST_T);
    wr(6'h00, 8'h10);
    gap(SLOW_T);
    // wake into continuous with hold until detector runs
    wr(6'h28, 8'h01);
    standby_req <= 1'b0;
    ticks(3);
    @(negedge sys_clk);
    chk_pin({6'h00, det_mode}, 8'h03);
    chk_pin({7'h00, exec_hold}, 8'h01);
    @(posedge sys_clk);
    detector_ready <= 1'b1;
    ticks(2);
    @(negedge sys_clk);
    chk_pin({7'h00, exec_hold}, 8'h00);
    complete_run();
  end

endmodule : brownout_monitor_control_test
